// ### src/dgrc_top.sv
// dgrc_top: range and clamp control for sixteen dac channels in four groups,
// with auto-range detection and the register file behind the serial port.
// assumes the serial port decodes frames into one-cycle read/write strobes.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - sixteen channels in four groups of four
// - one range and clamp per group
// - reset forces every output to clamp
// - reset returns dac data to defaults
// - below threshold selects minus ten range
// - above threshold selects zero-five range
// - detection outcome readable in general status
// - power-down or config write reruns detection
// - host range writes apply per group
// - optional clamp on alarm event
module dgrc_top #(
   parameter int SETTLE_CYC = dgrc_pkg::DET_SETTLE_CYC
) (
   input  wire logic        mclk,          // system clock, 50 MHz
   input  wire logic        resetn,        // async reset, active low
   input  wire logic        ce,            // clock enable, freezes state when low
   input  wire logic        reg_wr,        // register write strobe
   input  wire logic        reg_rd,        // register read strobe
   input  wire logic [7:0]  reg_addr,      // register address
   input  wire logic [7:0]  reg_wdata,     // register write data
   input  wire logic [3:0]  grp_below_thr, // per group supply pin below threshold
   input  wire logic        alarm_event,   // alarm detected
   output logic      [7:0]  reg_rdata,     // read data
   output logic             reg_rvalid,    // read data valid pulse
   output logic      [7:0]  grp_range,     // two bits of range per group
   output logic      [15:0] chan_clamp,    // per channel forced to clamp
   output logic      [15:0] chan_pd,       // per channel power down
   output logic             dac_defaults   // dac data and latches to default
);
   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   dgrc_det_if  det_if ();
   logic [7:0]  dev_cfg_r;
   logic [15:0] pd_r;
   logic [3:0]  clamp_grp_r;
   logic        rst_pend_r;
   logic        trig_r;

   wire acc_wr   = ce && reg_wr;
   wire wr_cfg   = acc_wr && (reg_addr == dgrc_pkg::ADDR_DEV_CFG);
   wire wr_pd_lo = acc_wr && (reg_addr == dgrc_pkg::ADDR_PD_LO);
   wire wr_pd_hi = acc_wr && (reg_addr == dgrc_pkg::ADDR_PD_HI);
   wire wr_rlo   = acc_wr && (reg_addr == dgrc_pkg::ADDR_RANGE_LO);
   wire wr_rhi   = acc_wr && (reg_addr == dgrc_pkg::ADDR_RANGE_HI);
   wire det_done = ce && det_if.done;
   wire auto_en  = dev_cfg_r[dgrc_pkg::CFG_AUTO_CLAMP_BIT];
   wire release_w = wr_cfg && reg_wdata[dgrc_pkg::CFG_RELEASE_BIT];

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dev_cfg_r <= dgrc_pkg::DEV_CFG_RST;
      end else if (wr_cfg) begin
         // release bit is a command and is not stored
         dev_cfg_r <= reg_wdata & ~(8'h01 << dgrc_pkg::CFG_RELEASE_BIT);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pd_r <= {2{dgrc_pkg::PD_RST}};
      end else begin
         if (wr_pd_lo) pd_r[7:0] <= reg_wdata;
         if (wr_pd_hi) pd_r[15:8] <= reg_wdata;
      end
   end

   // -------------------------------------------------------------------
   // detection trigger
   // -------------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_pend_r <= 1'b1;
         trig_r     <= 1'b0;
      end else if (ce) begin
         rst_pend_r <= 1'b0;
         trig_r     <= rst_pend_r || wr_cfg || wr_pd_lo || wr_pd_hi;
      end
   end

   assign det_if.trig  = trig_r;
   assign det_if.below = grp_below_thr;

   dgrc_autorange #(
      .SETTLE_CYC (SETTLE_CYC)
   ) u_det (
      .mclk   (mclk),
      .resetn (resetn),
      .ce     (ce),
      .det    (det_if.det)
   );

   // -------------------------------------------------------------------
   // per group range and clamp
   // -------------------------------------------------------------------
   logic [7:0] det_range;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_grp
         localparam int LANE = (g % 2) * dgrc_pkg::RANGE_FIELD_W;

         assign det_range[2*g +: 2] = det_if.result[g] ? dgrc_pkg::RANGE_NEG10
                                                       : dgrc_pkg::RANGE_POS5;

         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               grp_range[2*g +: 2] <= dgrc_pkg::RANGE_POS5;
            end else if (det_done) begin
               // detection overrides the host value
               grp_range[2*g +: 2] <= det_range[2*g +: 2];
            end else if ((g < 2) ? wr_rlo : wr_rhi) begin
               grp_range[2*g +: 2] <= reg_wdata[LANE +: 2];
            end
         end

         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               clamp_grp_r[g] <= dgrc_pkg::CLAMP_RST[g];
            end else if (ce && alarm_event && auto_en) begin
               clamp_grp_r[g] <= 1'b1;
            end else if (release_w) begin
               clamp_grp_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // per channel outputs
   // -------------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < 16; c++) begin : g_ch
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               chan_clamp[c] <= 1'b1;
               chan_pd[c]    <= 1'b0;
            end else if (ce) begin
               chan_clamp[c] <= clamp_grp_r[c / 4];
               chan_pd[c]    <= pd_r[c];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) dac_defaults <= 1'b1;
      else if (ce) dac_defaults <= 1'b0;
   end

   // -------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         dgrc_pkg::ADDR_DEV_CFG:  rd_mux = dev_cfg_r;
         dgrc_pkg::ADDR_RANGE_LO: rd_mux = {2'h0, grp_range[3:2], 2'h0, grp_range[1:0]};
         dgrc_pkg::ADDR_RANGE_HI: rd_mux = {2'h0, grp_range[7:6], 2'h0, grp_range[5:4]};
         dgrc_pkg::ADDR_GEN_STAT: rd_mux = {3'h0, det_if.busy, det_if.result};
         dgrc_pkg::ADDR_PD_LO:    rd_mux = pd_r[7:0];
         dgrc_pkg::ADDR_PD_HI:    rd_mux = pd_r[15:8];
         default:                 rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else if (ce) begin
         reg_rvalid <= reg_rd;
         if (reg_rd) reg_rdata <= rd_mux;
      end
   end

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   logic [15:0] clamp_exp;
   assign clamp_exp = {{4{clamp_grp_r[3]}}, {4{clamp_grp_r[2]}},
                       {4{clamp_grp_r[1]}}, {4{clamp_grp_r[0]}}};

   a_chan_group_map: assert property (ce |=> chan_clamp == $past(clamp_exp))
      else $error("channel clamp does not follow its group");
   a_defaults_clamp: assert property (dac_defaults |-> clamp_grp_r == 4'hf)
      else $error("defaults asserted while a group is unclamped");
   a_defaults_once: assert property (dac_defaults && ce |=> !dac_defaults)
      else $error("data default pulse longer than one cycle");
   a_det_apply: assert property (det_done |=> grp_range == $past(det_range))
      else $error("detected range not applied");
   a_det_pos_a: assert property (det_done && !det_if.result[0]
      |=> grp_range[1:0] == dgrc_pkg::RANGE_POS5)
      else $error("group a not set to zero-five range");
   a_stat_read: assert property (ce && reg_rd && reg_addr == dgrc_pkg::ADDR_GEN_STAT
      |=> reg_rvalid && reg_rdata[3:0] == $past(det_if.result))
      else $error("status does not show detection result");
   a_rerun_trig: assert property (wr_pd_hi ##1 ce |=> det_if.busy)
      else $error("power-down write did not rerun detection");
   a_range_write: assert property (wr_rhi && !det_done
      |=> grp_range[7:6] == $past(reg_wdata[5:4]))
      else $error("host range write not applied to group d");
   a_alarm_clamp: assert property (ce && alarm_event && auto_en
      |=> clamp_grp_r == 4'hf ##1 ce |=> chan_clamp == 16'hffff)
      else $error("alarm did not clamp outputs");
   a_range_hold: assert property (!det_done && !wr_rlo && !wr_rhi
      |=> $stable(grp_range))
      else $error("range changed without cause");

   a_busy_read: assert property (ce && reg_rd && reg_addr == dgrc_pkg::ADDR_GEN_STAT
      |=> reg_rdata[4] == $past(det_if.busy))
      else $error("status busy bit does not show detector state");
   a_cfg_rerun: assert property (wr_cfg ##1 ce |=> det_if.busy)
      else $error("config write did not rerun detection");
   a_pd_lo_rerun: assert property (wr_pd_lo ##1 ce |=> det_if.busy)
      else $error("power-down write did not rerun detection");
   a_range_lo_wr: assert property (wr_rlo && !det_done
      |=> grp_range[1:0] == $past(reg_wdata[1:0])
          && grp_range[3:2] == $past(reg_wdata[5:4]))
      else $error("host range write not applied to groups a and b");
   a_det_beats_wr: assert property (det_done && wr_rlo
      |=> grp_range[3:0] == $past(det_range[3:0]))
      else $error("range write won over detection");
   a_release_clr: assert property (release_w && !(alarm_event && auto_en)
      |=> clamp_grp_r == 4'h0)
      else $error("release write did not clear clamps");
   a_alarm_off: assert property (ce && !release_w && !(alarm_event && auto_en)
      |=> $stable(clamp_grp_r))
      else $error("clamp changed without alarm or release");
   a_pd_follow: assert property (ce |=> chan_pd == $past(pd_r))
      else $error("channel power down does not follow register");
   a_rvalid_low: assert property (ce && !reg_rd |=> !reg_rvalid)
      else $error("read valid without a read");
   a_rdata_hold: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_ce_freeze: assert property (!ce |=> $stable(grp_range) && $stable(chan_clamp))
      else $error("state moved while clock enable low");

   // -------------------------------------------------------------------
   // per group detection outcome and shared channel state
   // -------------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_chk
         a_det_neg_grp: assert property (det_done && det_if.result[k]
            |=> grp_range[2*k +: 2] == dgrc_pkg::RANGE_NEG10)
            else $error("group not set to minus ten range");
         a_det_pos_grp: assert property (det_done && !det_if.result[k]
            |=> grp_range[2*k +: 2] == dgrc_pkg::RANGE_POS5)
            else $error("group not set to zero-five range");
         a_grp_shared: assert property (chan_clamp[4*k +: 4] == 4'h0
            || chan_clamp[4*k +: 4] == 4'hf)
            else $error("channels of one group disagree on clamp");
      end
   endgenerate

   // -------------------------------------------------------------------
   // detection length
   // -------------------------------------------------------------------
   // busy time of one detection, bounded by the settle count
   logic [8:0] busy_cnt_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         busy_cnt_r <= 9'h000;
      end else if (ce) begin
         if (!det_if.busy || det_if.trig) busy_cnt_r <= 9'h000;
         else busy_cnt_r <= busy_cnt_r + 9'h001;
      end
   end

   a_busy_bound: assert property (busy_cnt_r <= 9'(SETTLE_CYC))
      else $error("detection did not finish in time");

   c_detect:  cover property (det_done && det_if.result != 4'h0);
   c_freeze:  cover property (!ce ##1 ce);
   c_alarm:   cover property (ce && alarm_event && auto_en && clamp_grp_r == 4'h0);
   c_write:   cover property (wr_rlo ##[1:20] det_done);
   c_release: cover property (release_w ##1 clamp_grp_r == 4'h0);

endmodule
`default_nettype wire

// ### src/dgrc_pkg.sv
// dgrc_pkg: register map, field layout, reset values and timing of the
// dac group range and clamp control.
// assumes an 8-bit register address space and a 50 MHz mclk.
package dgrc_pkg;

   // -------------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_DEV_CFG  = 8'h02;
   localparam logic [7:0] ADDR_RANGE_LO = 8'h1e;
   localparam logic [7:0] ADDR_RANGE_HI = 8'h1f;
   localparam logic [7:0] ADDR_GEN_STAT = 8'h72;
   localparam logic [7:0] ADDR_PD_LO    = 8'hb2;
   localparam logic [7:0] ADDR_PD_HI    = 8'hb3;

   // -------------------------------------------------------------------
   // fields
   // -------------------------------------------------------------------
   localparam int CFG_AUTO_CLAMP_BIT = 0;  // clamp on alarm enable
   localparam int CFG_RELEASE_BIT    = 1;  // write 1 releases clamps
   localparam int STAT_BUSY_BIT      = 4;  // detector running
   localparam int RANGE_FIELD_W      = 4;  // one nibble per group

   // -------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] DEV_CFG_RST = 8'h00;
   localparam logic [7:0] PD_RST      = 8'h00;
   localparam logic [3:0] CLAMP_RST   = 4'hf;

   // -------------------------------------------------------------------
   // range codes
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      RANGE_POS5  = 2'h0,
      RANGE_POS10 = 2'h1,
      RANGE_NEG5  = 2'h2,
      RANGE_NEG10 = 2'h3
   } dgrc_range_t;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int MCLK_PERIOD_NS  = 20;
   localparam int DET_SETTLE_NS   = 1000;
   localparam int DET_SETTLE_CYC  = (DET_SETTLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

endpackage

// ### src/dgrc_det_if.sv
// dgrc_det_if: link between the control block and the auto-range detector.
// assumes one clock domain, mclk.
`timescale 1ns/100ps
`default_nettype none
interface dgrc_det_if;
   logic       trig;    // start or restart a detection
   logic [3:0] below;   // per group: supply pin below threshold
   logic       done;    // detection finished
   logic       busy;    // detection in progress
   logic [3:0] result;  // captured below flags

   modport ctrl (output trig, below, input done, busy, result);
   modport det  (input trig, below, output done, busy, result);
endinterface
`default_nettype wire

// ### src/dgrc_autorange.sv
// dgrc_autorange: waits for the group supply comparators to settle, then
// captures one below-threshold flag per group.
// assumes comparator outputs synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module dgrc_autorange #(
   parameter int SETTLE_CYC = dgrc_pkg::DET_SETTLE_CYC
) (
   input  wire logic mclk,    // system clock
   input  wire logic resetn,  // async reset, active low
   input  wire logic ce,      // clock enable
   dgrc_det_if.det   det      // detector link
);
   typedef enum logic {DGRC_IDLE, DGRC_SETTLE} dgrc_det_st_t;

   dgrc_det_st_t st_r;
   logic [7:0]   cnt_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_r  <= DGRC_IDLE;
         cnt_r <= 8'h00;
      end else if (ce) begin
         unique case (st_r)
            DGRC_IDLE: begin
               cnt_r <= 8'h00;
               if (det.trig) st_r <= DGRC_SETTLE;
            end
            DGRC_SETTLE: begin
               // a new trigger restarts the settle wait
               if (det.trig) begin
                  cnt_r <= 8'h00;
               end else if (cnt_r == 8'(SETTLE_CYC - 1)) begin
                  st_r <= DGRC_IDLE;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
         endcase
      end
   end

   wire capture = (st_r == DGRC_SETTLE) && !det.trig && (cnt_r == 8'(SETTLE_CYC - 1));

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) det.done <= 1'b0;
      else if (ce) det.done <= capture;
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_grp
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) det.result[g] <= 1'b0;
            else if (ce && capture) det.result[g] <= det.below[g];
         end
      end
   endgenerate

   assign det.busy = (st_r == DGRC_SETTLE);

   a_trig_busy: assert property (@(posedge mclk) disable iff (!resetn)
      ce && det.trig |=> det.busy) else $error("detector did not start");

endmodule
`default_nettype wire

// ### tb/dgrc_host_model.sv
// dgrc_host_model: host side of the register port, issues one-cycle strobes.
// assumes the register port takes a strobe on the rising mclk edge.
`timescale 1ns/100ps
`default_nettype none
module dgrc_host_model (
   input  wire logic       mclk,        // system clock
   input  wire logic [7:0] reg_rdata,   // read data
   input  wire logic       reg_rvalid,  // read data valid
   output var  logic       reg_wr,      // write strobe
   output var  logic       reg_rd,      // read strobe
   output var  logic [7:0] reg_addr,    // register address
   output var  logic [7:0] reg_wdata    // write data
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // released address and data show the inverse, never a stale value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      // answer launched at the taking edge; sample before releasing
      @(negedge mclk);
      ok = reg_rvalid;
      d = reg_rdata;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
endmodule
`default_nettype wire

// ### tb/test_dac_group_range_clamp_ctrl.sv
// test_dac_group_range_clamp_ctrl: self-checking bench for dgrc_top.
// assumes dgrc_pkg and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_dac_group_range_clamp_ctrl;
   localparam int SETTLE = 4;
   logic        mclk, resetn, ce, alarm_event, reg_wr, reg_rd, reg_rvalid, dac_defaults;
   logic [3:0]  grp_below_thr;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, grp_range, lo, hi, pd;
   logic [15:0] chan_clamp, chan_pd, pd_exp;
   int          seed, n_fail, samples_checked, cyc;

   dgrc_top #(.SETTLE_CYC(SETTLE)) dgrc_top_inst (
      .mclk(mclk), .resetn(resetn), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .grp_below_thr(grp_below_thr),
      .alarm_event(alarm_event), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .grp_range(grp_range), .chan_clamp(chan_clamp), .chan_pd(chan_pd),
      .dac_defaults(dac_defaults));

   dgrc_host_model dgrc_host_model_inst (
      .mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   // -------------------------------------------------------------------
   // expectations and checks
   // -------------------------------------------------------------------
   function automatic logic [7:0] det_range(input logic [3:0] b);
      for (int g = 0; g < 4; g++) begin
         det_range[2*g +: 2] = b[g] ? dgrc_pkg::RANGE_NEG10 : dgrc_pkg::RANGE_POS5;
      end
   endfunction

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      dgrc_host_model_inst.rd(a, d, ok);
      chk8({7'h00, ok}, 8'h01);
      chk8(d, exp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      dgrc_host_model_inst.wr(a, d);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic end_sim;
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // -------------------------------------------------------------------
   // clock and hang guard
   // -------------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         end_sim();
      end
   end

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      seed = 24;
      resetn = 1'b0;
      ce = 1'b1;
      alarm_event = 1'b0;
      pd_exp = 16'h0000;
      grp_below_thr = 4'($random(seed));
      wait_cyc(4);
      chk16(chan_clamp, 16'hffff);
      chk16({15'h0000, dac_defaults}, 16'h0001);
      chk16(chan_pd, 16'h0000);
      repeat (4) @(negedge mclk);
      resetn = 1'b1;
      wait_cyc(SETTLE + 4);
      chk16({15'h0000, dac_defaults}, 16'h0000);
      chk8(grp_range, det_range(grp_below_thr));
      rdchk(dgrc_pkg::ADDR_GEN_STAT, {4'h0, grp_below_thr});
      chk16(chan_clamp, 16'hffff);
      // release, then alarm while disabled, then alarm while enabled
      wr(dgrc_pkg::ADDR_DEV_CFG, 8'h02);
      wait_cyc(3);
      chk16(chan_clamp, 16'h0000);
      @(negedge mclk);
      alarm_event = 1'b1;
      wait_cyc(3);
      chk16(chan_clamp, 16'h0000);
      wr(dgrc_pkg::ADDR_DEV_CFG, 8'h01);
      wait_cyc(3);
      chk16(chan_clamp, 16'hffff);
      @(negedge mclk);
      alarm_event = 1'b0;
      wr(dgrc_pkg::ADDR_DEV_CFG, 8'h02);
      wait_cyc(SETTLE + 4);
      for (int i = 0; i < 15; i++) begin
         lo = 8'($random(seed));
         hi = 8'($random(seed));
         pd = 8'($random(seed));
         wr(dgrc_pkg::ADDR_RANGE_LO, lo);
         wr(dgrc_pkg::ADDR_RANGE_HI, hi);
         alarm_event = 1'($random(seed));
         chk8(grp_range, {hi[5:4], hi[1:0], lo[5:4], lo[1:0]});
         rdchk(dgrc_pkg::ADDR_RANGE_HI, hi & 8'h33);
         grp_below_thr = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
         case (i % 3)
            0: wr(dgrc_pkg::ADDR_DEV_CFG, 8'h00);
            1: begin
               wr(dgrc_pkg::ADDR_PD_LO, pd);
               pd_exp[7:0] = pd;
            end
            default: begin
               wr(dgrc_pkg::ADDR_PD_HI, pd);
               pd_exp[15:8] = pd;
            end
         endcase
         wait_cyc(SETTLE + 4);
         chk8(grp_range, det_range(grp_below_thr));
         rdchk(dgrc_pkg::ADDR_GEN_STAT, {4'h0, grp_below_thr});
         chk16(chan_pd, pd_exp);
         chk16(chan_clamp, 16'h0000);
      end
      // clock enable low freezes the register port
      @(negedge mclk);
      ce = 1'b0;
      lo = grp_range;
      wr(dgrc_pkg::ADDR_RANGE_LO, ~lo);
      wait_cyc(2);
      chk8(grp_range, lo);
      @(negedge mclk);
      ce = 1'b1;
      // status is read only; an unmapped place reads zero
      wr(dgrc_pkg::ADDR_GEN_STAT, 8'hff);
      rdchk(dgrc_pkg::ADDR_GEN_STAT, {4'h0, grp_below_thr});
      rdchk(8'h40, 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
